//--- include/ccsd_defines.svh
// Purpose: Constants for the call, compare and skip execution block
// Assumes: 16-bit program counter, 8-bit status register
// Notes: Flag positions follow the core status register layout
`ifndef CCSD_DEFINES_SVH
`define CCSD_DEFINES_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define CCSD_PC_W 16
`define CCSD_K_W 12
`define CCSD_DATA_W 8

// ----------------------------------------
// Status flag positions
// ----------------------------------------
`define CCSD_FLAG_C 0
`define CCSD_FLAG_Z 1
`define CCSD_FLAG_N 2
`define CCSD_FLAG_V 3
`define CCSD_FLAG_H 5
`define CCSD_FLAG_I 7

// ----------------------------------------
// Program counter steps and reset values
// ----------------------------------------
`define CCSD_STEP_ONE 16'h0001
`define CCSD_STEP_TWO 16'h0002
`define CCSD_STEP_THREE 16'h0003
`define CCSD_PC_RST 16'h0000
`define CCSD_SREG_RST 8'h00

`endif

//--- include/ccsd_pkg.sv
// Purpose: Types for the call, compare and skip execution block
// Assumes: Operations arrive already decoded from the fetch unit
// Notes: Operation codes are internal to the core
package ccsd_pkg;

	// ----------------------------------------
	// Decoded operations
	// ----------------------------------------
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_RELATIVE_CALL = 4'h1,
		OP_INDIRECT_CALL = 4'h2,
		OP_SUBROUTINE_RETURN = 4'h3,
		OP_INTERRUPT_RETURN = 4'h4,
		OP_COMPARE_SKIP_EQUAL = 4'h5,
		OP_REGISTER_COMPARE = 4'h6,
		OP_COMPARE_WITH_CARRY = 4'h7,
		OP_COMPARE_IMMEDIATE = 4'h8,
		OP_SKIP_REG_BIT_CLEAR = 4'h9,
		OP_SKIP_REG_BIT_SET = 4'hA,
		OP_SKIP_IO_BIT_CLEAR = 4'hB,
		OP_SKIP_IO_BIT_SET = 4'hC
	} ccsd_op_e;

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_READY = 2'b01,
		ST_POP_WAIT = 2'b10
	} ccsd_state_e;

endpackage

//--- design/ccsd_compare.sv
// Purpose: Compare subtraction producing the arithmetic flags
// Assumes: Combinational, same clock domain as the caller
// Notes: The difference itself is never stored
`timescale 1ns/10ps
`include "ccsd_defines.svh"

module ccsd_compare
(
	// Operands
	input wire logic [`CCSD_DATA_W-1:0] left_i,
	input wire logic [`CCSD_DATA_W-1:0] right_i,
	input wire logic carry_in_i,
	input wire logic keep_zero_i,
	input wire logic [`CCSD_DATA_W-1:0] sreg_i,
	// Result
	output logic [`CCSD_DATA_W-1:0] sreg_o
);
	import ccsd_pkg::*;

	logic [`CCSD_DATA_W:0] diff;
	logic [`CCSD_DATA_W-1:0] res;
	logic zero;

	// ----------------------------------------
	// Flag computation
	// ----------------------------------------
	always_comb
	begin
		diff = {1'b0, left_i} - {1'b0, right_i} - {{`CCSD_DATA_W{1'b0}}, carry_in_i};
		res = diff[`CCSD_DATA_W-1:0];
		zero = (res == '0);
		sreg_o = sreg_i;
		sreg_o[`CCSD_FLAG_C] = diff[`CCSD_DATA_W];
		sreg_o[`CCSD_FLAG_Z] = keep_zero_i ? (zero & sreg_i[`CCSD_FLAG_Z]) : zero;
		sreg_o[`CCSD_FLAG_N] = res[`CCSD_DATA_W-1];
		sreg_o[`CCSD_FLAG_V] = (left_i[7] & ~right_i[7] & ~res[7]) |
			(~left_i[7] & right_i[7] & res[7]);
		sreg_o[`CCSD_FLAG_H] = (~left_i[3] & right_i[3]) | (right_i[3] & res[3]) |
			(res[3] & ~left_i[3]);
	end

endmodule // ccsd_compare

//--- design/ccsd_exec.sv
// Purpose: Executes calls, returns, compares and conditional skips
// Assumes: Fetch supplies a decoded operation, operands and next-word length
// Notes: Results appear one clock after a non-return operation is taken; returns finish once the pop is answered
`timescale 1ns/10ps
`include "ccsd_defines.svh"

module ccsd_exec
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// Operation from fetch
	input wire logic op_valid_i,
	input wire ccsd_pkg::ccsd_op_e op_i,
	input wire logic [`CCSD_PC_W-1:0] pc_i,
	input wire logic [`CCSD_K_W-1:0] offset_i,
	input wire logic [2:0] bit_sel_i,
	input wire logic [`CCSD_DATA_W-1:0] imm_i,
	input wire logic next_two_word_i,
	// Operands from register file
	input wire logic [`CCSD_DATA_W-1:0] rd_val_i,
	input wire logic [`CCSD_DATA_W-1:0] rr_val_i,
	input wire logic [`CCSD_DATA_W-1:0] io_val_i,
	input wire logic [`CCSD_PC_W-1:0] z_ptr_i,
	input wire logic [`CCSD_DATA_W-1:0] sreg_i,
	// Stack pop answer
	input wire logic pop_valid_i,
	input wire logic [`CCSD_PC_W-1:0] pop_data_i,
	// Program counter
	output logic pc_load_o,
	output logic [`CCSD_PC_W-1:0] pc_o,
	// Stack requests
	output logic push_o,
	output logic [`CCSD_PC_W-1:0] push_data_o,
	output logic pop_o,
	// Status register
	output logic sreg_we_o,
	output logic [`CCSD_DATA_W-1:0] sreg_o,
	// Progress
	output logic busy_o,
	output logic done_o
);
	import ccsd_pkg::*;

	ccsd_state_e state_q, state_d;
	logic interrupt_return_q, interrupt_return_d;
	logic pc_load_q, pc_load_d;
	logic [`CCSD_PC_W-1:0] pc_q, pc_d;
	logic push_q, push_d;
	logic [`CCSD_PC_W-1:0] push_data_q, push_data_d;
	logic pop_q, pop_d;
	logic sreg_we_q, sreg_we_d;
	logic [`CCSD_DATA_W-1:0] sreg_q, sreg_d;
	logic busy_q, busy_d;
	logic done_q, done_d;
	logic [`CCSD_DATA_W-1:0] cmp_right;
	logic cmp_carry;
	logic [`CCSD_DATA_W-1:0] cmp_sreg;
	logic take;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [`CCSD_PC_W-1:0] skip_target(
		input logic [`CCSD_PC_W-1:0] pc,
		input logic skip,
		input logic two_word
	);
		if (!skip)
			skip_target = pc + `CCSD_STEP_ONE;
		else if (two_word)
			skip_target = pc + `CCSD_STEP_THREE;
		else
			skip_target = pc + `CCSD_STEP_TWO;
	endfunction

	function automatic logic [`CCSD_PC_W-1:0] sext_offset(input logic [`CCSD_K_W-1:0] k);
		sext_offset = {{(`CCSD_PC_W-`CCSD_K_W){k[`CCSD_K_W-1]}}, k};
	endfunction

	// ----------------------------------------
	// Compare unit
	// ----------------------------------------
	assign cmp_right = (op_i == OP_COMPARE_IMMEDIATE) ? imm_i : rr_val_i;
	assign cmp_carry = (op_i == OP_COMPARE_WITH_CARRY) ? sreg_i[`CCSD_FLAG_C] : 1'b0;

	ccsd_compare u_compare
	(
		.left_i(rd_val_i),
		.right_i(cmp_right),
		.carry_in_i(cmp_carry),
		.keep_zero_i(op_i == OP_COMPARE_WITH_CARRY),
		.sreg_i(sreg_i),
		.sreg_o(cmp_sreg)
	);

	assign take = op_valid_i && (state_q == ST_READY);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		state_d = state_q;
		interrupt_return_d = interrupt_return_q;
		pc_load_d = 1'b0;
		pc_d = pc_q;
		push_d = 1'b0;
		push_data_d = push_data_q;
		pop_d = 1'b0;
		sreg_we_d = 1'b0;
		sreg_d = sreg_q;
		busy_d = busy_q;
		done_d = 1'b0;
		unique case (state_q)
			ST_READY:
			begin
				if (take)
				begin
					unique case (op_i)
						OP_RELATIVE_CALL:
						begin
							pc_load_d = 1'b1;
							pc_d = pc_i + sext_offset(offset_i) + `CCSD_STEP_ONE;
							push_d = 1'b1;
							push_data_d = pc_i + `CCSD_STEP_ONE;
							done_d = 1'b1;
						end
						OP_INDIRECT_CALL:
						begin
							pc_load_d = 1'b1;
							pc_d = z_ptr_i;
							push_d = 1'b1;
							push_data_d = pc_i + `CCSD_STEP_ONE;
							done_d = 1'b1;
						end
						OP_SUBROUTINE_RETURN, OP_INTERRUPT_RETURN:
						begin
							pop_d = 1'b1;
							interrupt_return_d = (op_i == OP_INTERRUPT_RETURN);
							busy_d = 1'b1;
							state_d = ST_POP_WAIT;
						end
						OP_COMPARE_SKIP_EQUAL:
						begin
							pc_load_d = 1'b1;
							pc_d = skip_target(pc_i, rd_val_i == rr_val_i, next_two_word_i);
							done_d = 1'b1;
						end
						OP_REGISTER_COMPARE, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMMEDIATE:
						begin
							pc_load_d = 1'b1;
							pc_d = pc_i + `CCSD_STEP_ONE;
							sreg_we_d = 1'b1;
							sreg_d = cmp_sreg;
							done_d = 1'b1;
						end
						OP_SKIP_REG_BIT_CLEAR:
						begin
							pc_load_d = 1'b1;
							pc_d = skip_target(pc_i, !rr_val_i[bit_sel_i], next_two_word_i);
							done_d = 1'b1;
						end
						OP_SKIP_REG_BIT_SET:
						begin
							pc_load_d = 1'b1;
							pc_d = skip_target(pc_i, rr_val_i[bit_sel_i], next_two_word_i);
							done_d = 1'b1;
						end
						OP_SKIP_IO_BIT_CLEAR:
						begin
							pc_load_d = 1'b1;
							pc_d = skip_target(pc_i, !io_val_i[bit_sel_i], next_two_word_i);
							done_d = 1'b1;
						end
						OP_SKIP_IO_BIT_SET:
						begin
							pc_load_d = 1'b1;
							pc_d = skip_target(pc_i, io_val_i[bit_sel_i], next_two_word_i);
							done_d = 1'b1;
						end
						default:
						begin
							done_d = 1'b0;
						end
					endcase
				end
			end
			ST_POP_WAIT:
			begin
				if (pop_valid_i)
				begin
					pc_load_d = 1'b1;
					pc_d = pop_data_i;
					if (interrupt_return_q)
					begin
						sreg_we_d = 1'b1;
						sreg_d = sreg_i;
						sreg_d[`CCSD_FLAG_I] = 1'b1;
					end
					interrupt_return_d = 1'b0;
					busy_d = 1'b0;
					done_d = 1'b1;
					state_d = ST_READY;
				end
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge core_clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state_q <= ST_READY;
			interrupt_return_q <= 1'b0;
			pc_load_q <= 1'b0;
			pc_q <= `CCSD_PC_RST;
			push_q <= 1'b0;
			push_data_q <= `CCSD_PC_RST;
			pop_q <= 1'b0;
			sreg_we_q <= 1'b0;
			sreg_q <= `CCSD_SREG_RST;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			interrupt_return_q <= interrupt_return_d;
			pc_load_q <= pc_load_d;
			pc_q <= pc_d;
			push_q <= push_d;
			push_data_q <= push_data_d;
			pop_q <= pop_d;
			sreg_we_q <= sreg_we_d;
			sreg_q <= sreg_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign pc_load_o = pc_load_q;
	assign pc_o = pc_q;
	assign push_o = push_q;
	assign push_data_o = push_data_q;
	assign pop_o = pop_q;
	assign sreg_we_o = sreg_we_q;
	assign sreg_o = sreg_q;
	assign busy_o = busy_q;
	assign done_o = done_q;

endmodule // ccsd_exec

//--- dv/ccsd_checker.sv
// Purpose: Port checks for the call, compare and skip block
// Assumes: Ports of ccsd_exec, one clock domain
// Notes: Bound to every ccsd_exec instance
`timescale 1ns/10ps
`include "ccsd_defines.svh"
module ccsd_checker
(
	// Inputs
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic op_valid_i,
	input wire ccsd_pkg::ccsd_op_e op_i,
	input wire logic [`CCSD_PC_W-1:0] pc_i,
	input wire logic [`CCSD_K_W-1:0] offset_i,
	input wire logic [2:0] bit_sel_i,
	input wire logic [`CCSD_DATA_W-1:0] imm_i,
	input wire logic next_two_word_i,
	input wire logic [`CCSD_DATA_W-1:0] rd_val_i,
	input wire logic [`CCSD_DATA_W-1:0] rr_val_i,
	input wire logic [`CCSD_DATA_W-1:0] io_val_i,
	input wire logic [`CCSD_PC_W-1:0] z_ptr_i,
	input wire logic [`CCSD_DATA_W-1:0] sreg_i,
	input wire logic pop_valid_i,
	input wire logic [`CCSD_PC_W-1:0] pop_data_i,
	// Outputs
	input wire logic pc_load_o,
	input wire logic [`CCSD_PC_W-1:0] pc_o,
	input wire logic push_o,
	input wire logic [`CCSD_PC_W-1:0] push_data_o,
	input wire logic pop_o,
	input wire logic sreg_we_o,
	input wire logic [`CCSD_DATA_W-1:0] sreg_o,
	input wire logic busy_o,
	input wire logic done_o
);
	import ccsd_pkg::*;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	logic take, eq, cz, lt, rhit, ihit, interrupt_return_q;
	logic [7:0] dif;
	logic [2:0] cflg;
	logic [15:0] tgt, adv;
	logic [2:0] keep;
	assign take = op_valid_i && !busy_o;
	assign eq = rd_val_i == rr_val_i;
	assign cz = rd_val_i == imm_i;
	assign lt = rd_val_i < imm_i;
	assign dif = rd_val_i - imm_i;
	assign cflg = {dif[7], cz, lt};
	assign rhit = rr_val_i[bit_sel_i] == (op_i == OP_SKIP_REG_BIT_SET);
	assign ihit = io_val_i[bit_sel_i] == (op_i == OP_SKIP_IO_BIT_SET);
	assign tgt = pc_i + {{4{offset_i[11]}}, offset_i} + 16'h0001;
	assign adv = pc_i + (next_two_word_i ? 16'h0003 : 16'h0002);
	assign keep = {sreg_i[7:6], sreg_i[4]};
	always_ff @(posedge core_clk_i or posedge reset_i)
		if (reset_i)
			interrupt_return_q <= 1'b0;
		else
			interrupt_return_q <= (take && op_i == OP_INTERRUPT_RETURN) || (interrupt_return_q && !done_o);
	relative_call_pc_a:
	assert property (take && op_i == OP_RELATIVE_CALL |=> pc_load_o && pc_o == $past(tgt))
		else $error("relative call target wrong");
	call_push_a:
	assert property (take && (op_i == OP_RELATIVE_CALL || op_i == OP_INDIRECT_CALL)
		|=> push_o && push_data_o == $past(pc_i) + 16'h0001) else $error("call push wrong");
	indirect_call_pc_a:
	assert property (take && op_i == OP_INDIRECT_CALL |=> pc_o == $past(z_ptr_i) && !sreg_we_o)
		else $error("indirect call wrong");
	compare_skip_equal_skip_a:
	assert property (take && op_i == OP_COMPARE_SKIP_EQUAL |=> !sreg_we_o
		&& pc_o == ($past(eq) ? $past(adv) : $past(pc_i) + 16'h0001)) else $error("compare_skip_equal wrong");
	cpi_flags_a:
	assert property (take && op_i == OP_COMPARE_IMMEDIATE |=> sreg_we_o
		&& sreg_o[2:0] == $past(cflg)
		&& {sreg_o[7:6], sreg_o[4]} == $past(keep)) else $error("compare flags wrong");
	reg_skip_a:
	assert property (take && (op_i == OP_SKIP_REG_BIT_CLEAR || op_i == OP_SKIP_REG_BIT_SET)
		|=> !sreg_we_o && pc_o == ($past(rhit) ? $past(adv) : $past(pc_i) + 16'h0001))
		else $error("register skip wrong");
	io_skip_a:
	assert property (take && (op_i == OP_SKIP_IO_BIT_CLEAR || op_i == OP_SKIP_IO_BIT_SET)
		|=> pc_o == ($past(ihit) ? $past(adv) : $past(pc_i) + 16'h0001)) else $error("io skip wrong");
	ret_pop_a:
	assert property (take && (op_i == OP_SUBROUTINE_RETURN || op_i == OP_INTERRUPT_RETURN)
		|=> pop_o && busy_o && !pc_load_o) else $error("return pop missing");
	ret_load_a:
	assert property (busy_o && pop_valid_i |=> done_o && !busy_o && pc_o == $past(pop_data_i))
		else $error("return load wrong");
	interrupt_return_ie_a:
	assert property (busy_o && pop_valid_i |=> sreg_we_o == $past(interrupt_return_q) && (!sreg_we_o || sreg_o[7]))
		else $error("interrupt enable wrong");
endmodule // ccsd_checker
bind ccsd_exec ccsd_checker u_chk (.*);

//--- dv/ccsd_stack_model.sv
// Purpose: Stack model answering pop requests
// Assumes: One pop outstanding at a time
// Notes: Data shows inverted last value while idle
`timescale 1ns/10ps
module ccsd_stack_model
(
	// Control
	input wire logic core_clk_i,
	input wire logic pop_req_i,
	input wire logic [3:0] lat_i,
	input wire logic [15:0] top_i,
	// Answer
	output logic pop_valid_o,
	output logic [15:0] pop_data_o
);
	initial
	begin
		pop_valid_o = 1'b0;
		pop_data_o = 16'hFFFF;
		forever
		begin
			@(posedge core_clk_i);
			if (pop_req_i)
			begin
				repeat (lat_i) @(posedge core_clk_i);
				pop_valid_o <= 1'b1;
				pop_data_o <= top_i;
				@(posedge core_clk_i);
				pop_valid_o <= 1'b0;
				pop_data_o <= ~top_i;
			end
		end
	end
endmodule // ccsd_stack_model

//--- dv/tb_top.sv
// Purpose: Self-checking bench for the call, compare and skip block
// Assumes: Results one clock after a non-return operation is taken; returns wait for the pop
// Notes: Returns answered by the stack model
`timescale 1ns/10ps
module tb_top;
	import ccsd_pkg::*;
	logic core_clk_i, reset_i, op_valid_i, next_two_word_i, pop_valid_i;
	ccsd_op_e op_i;
	logic [15:0] pc_i, z_ptr_i, pop_data_i, top, pc_o, push_data_o;
	logic [11:0] offset_i;
	logic [2:0] bit_sel_i;
	logic [7:0] imm_i, rd_val_i, rr_val_i, io_val_i, sreg_i, sreg_o;
	logic [3:0] lat;
	logic pc_load_o, push_o, pop_o, sreg_we_o, busy_o, done_o;
	int n_errors, tests_run;
	ccsd_exec u_dut (.*);
	ccsd_stack_model u_stack (.core_clk_i(core_clk_i), .pop_req_i(pop_o), .lat_i(lat),
		.top_i(top), .pop_valid_o(pop_valid_i), .pop_data_o(pop_data_i));
	initial
	begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic go(input ccsd_op_e o);
		@(posedge core_clk_i);
		op_i <= o;
		op_valid_i <= 1'b1;
		@(posedge core_clk_i);
		op_valid_i <= 1'b0;
		#1;
	endtask
	task automatic t_calls;
		@(posedge core_clk_i);
		pc_i <= 16'h1000;
		offset_i <= 12'h800;
		go(OP_RELATIVE_CALL);
		cmp("relative_call pc", 16'h0801, pc_o);
		cmp("relative_call push", 16'h1001, push_data_o);
		@(posedge core_clk_i);
		offset_i <= 12'h7FF;
		z_ptr_i <= 16'hBEEF;
		go(OP_RELATIVE_CALL);
		cmp("relative_call fwd", 16'h1800, pc_o);
		go(OP_INDIRECT_CALL);
		cmp("indirect_call pc", 16'hBEEF, pc_o);
		cmp("indirect_call flags", 16'h0000, sreg_we_o);
		cmp("indirect_call push", 16'h0001, push_o);
	endtask
	task automatic t_cmp;
		@(posedge core_clk_i);
		rd_val_i <= 8'h10;
		imm_i <= 8'h20;
		sreg_i <= 8'hD0;
		go(OP_COMPARE_IMMEDIATE);
		cmp("cpi sreg", 16'h01D5, {sreg_we_o, sreg_o});
		@(posedge core_clk_i);
		rd_val_i <= 8'h33;
		imm_i <= 8'h33;
		sreg_i <= 8'h2F;
		rr_val_i <= 8'h33;
		next_two_word_i <= 1'b1;
		go(OP_COMPARE_IMMEDIATE);
		cmp("cpi zero", 16'h0102, {sreg_we_o, sreg_o});
		go(OP_COMPARE_SKIP_EQUAL);
		cmp("compare_skip_equal eq", 16'h1003, pc_o);
		cmp("compare_skip_equal flags", 16'h0000, sreg_we_o);
		@(posedge core_clk_i);
		rr_val_i <= 8'h34;
		go(OP_COMPARE_SKIP_EQUAL);
		cmp("compare_skip_equal ne", 16'h1001, pc_o);
		go(OP_REGISTER_COMPARE);
		cmp("cp sreg", 16'h0125, {sreg_we_o, sreg_o});
		@(posedge core_clk_i);
		rr_val_i <= 8'h32;
		go(OP_COMPARE_WITH_CARRY);
		cmp("cpc keep z", 16'h0102, {sreg_we_o, sreg_o});
		@(posedge core_clk_i);
		sreg_i <= 8'h2D;
		go(OP_COMPARE_WITH_CARRY);
		cmp("cpc clear z", 16'h0100, {sreg_we_o, sreg_o});
	endtask
	task automatic t_skips;
		ccsd_op_e ops [4] = '{OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
			OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET};
		logic hit;
		for (int i = 0; i < 4; i++)
			for (int j = 0; j < 2; j++)
			begin
				@(posedge core_clk_i);
				pc_i <= 16'h0200;
				rr_val_i <= i < 2 ? 8'h04 : 8'hFB;
				io_val_i <= i < 2 ? 8'hFB : 8'h04;
				bit_sel_i <= j ? 3'h3 : 3'h2;
				next_two_word_i <= j[0];
				go(ops[i]);
				hit = i[0] ^ j[0];
				cmp("skip pc", 16'h0200 + (hit ? (j ? 16'h0003 : 16'h0002) : 16'h0001), pc_o);
				cmp("skip flags", 16'h0000, sreg_we_o);
			end
	endtask
	task automatic t_ret(input ccsd_op_e o, input logic [3:0] l, input logic [8:0] e);
		@(posedge core_clk_i);
		lat <= l;
		top <= 16'h4321 + l;
		sreg_i <= 8'h05;
		go(o);
		cmp("ret pop", 16'h0003, {pop_o, busy_o});
		for (int i = 0; i < 20 && done_o !== 1'b1; i++)
			@(posedge core_clk_i) #1;
		cmp("ret done", 16'h0003, {pc_load_o, done_o});
		cmp("ret pc", 16'h4321 + l, pc_o);
		cmp("ret sreg", e, sreg_we_o ? {1'b1, sreg_o} : 9'h000);
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		{op_valid_i, next_two_word_i, pc_i, z_ptr_i, top, offset_i, bit_sel_i} = '0;
		{imm_i, rd_val_i, rr_val_i, io_val_i, sreg_i, lat} = '0;
		op_i = OP_NONE;
		reset_i = 1'b1;
		repeat (6) @(posedge core_clk_i);
		reset_i <= 1'b0;
		t_calls();
		t_cmp();
		t_skips();
		t_ret(OP_SUBROUTINE_RETURN, 4'h3, 9'h000);
		t_ret(OP_INTERRUPT_RETURN, 4'h0, 9'h185);
		wrap_up();
	end
	initial
	begin
		#5000;
		n_errors++;
		wrap_up();
	end
endmodule // tb_top
